// ### cie_pkg.sv
package cie_pkg;

  // Widths and depths
  localparam int PC_W        = 13;
  localparam int STACK_DEPTH = 8;
  localparam int STACK_PTR_W = 3;

  // Opcode fields and match values
  localparam logic [3:0]  LIT_LOAD_TOP  = 4'hc;    // 11 00xx
  localparam logic [3:0]  LIT_RET_TOP   = 4'hd;    // 11 01xx
  localparam logic [6:0]  STORE_TOP     = 7'h01;   // 00 0000 1
  localparam logic [5:0]  ROT_LEFT_TOP  = 6'h0d;   // 00 1101
  localparam logic [5:0]  ROT_RIGHT_TOP = 6'h0c;   // 00 1100
  localparam logic [13:0] OPC_RETURN    = 14'h0008;
  localparam logic [13:0] OPC_RET_IRQ   = 14'h0009;
  localparam logic [13:0] OPC_SLEEP     = 14'h0063;
  localparam int          DEST_BIT      = 7;

  // Register port map (word index)
  localparam logic [1:0] REG_ACC    = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam logic [1:0] REG_IRQCTL = 2'h2;

  // Status and irq control field positions
  localparam int ST_CARRY_BIT     = 0;
  localparam int ST_POWERDOWN_BIT = 1;
  localparam int ST_TO_BIT        = 2;
  localparam int IRQ_ENABLE_BIT   = 7;

  // Reset values
  localparam logic [7:0]      ACC_RST       = 8'h00;
  localparam logic [7:0]      IRQCTL_RST    = 8'h00;
  localparam logic [PC_W-1:0] PC_RST        = 13'h0000;
  localparam logic            POWERDOWN_RST = 1'b1;
  localparam logic            TO_RST        = 1'b1;
  localparam logic            CARRY_RST     = 1'b0;

  // Core sequencing states
  typedef enum logic [1:0] {
    ST_RUN,
    ST_FLUSH,
    ST_SLEEP
  } cie_state_t;

  // Decoded instruction classes
  typedef struct packed {
    logic lit_load;
    logic store;
    logic ret;
    logic ret_lit;
    logic ret_irq;
    logic rot_left;
    logic rot_right;
    logic sleep;
  } cie_dec_t;

  // File register write request
  typedef struct packed {
    logic       we;
    logic [6:0] addr;
    logic [7:0] data;
  } cie_file_wr_t;

endpackage : cie_pkg

// ### cie_ret_stack.sv
`timescale 1ns/1ps
`default_nettype none
module cie_ret_stack
  import cie_pkg::*;
(
  // Clock and reset
  input  wire logic            clk_i,
  input  wire logic            nrst_i,
  // Push and pop
  input  wire logic            push_i,
  input  wire logic [PC_W-1:0] push_data_i,
  input  wire logic            pop_i,
  // Top entry
  output logic [PC_W-1:0]      top_o
);

  logic [PC_W-1:0]        mem [STACK_DEPTH];
  logic [STACK_PTR_W-1:0] ptr_reg;
  logic [STACK_PTR_W-1:0] ptr_next;
  logic [STACK_PTR_W-1:0] top_idx;

  // Circular stack; overflow wraps over the oldest entry
  assign top_idx  = ptr_reg - 3'h1;
  assign top_o    = mem[top_idx];
  assign ptr_next = push_i ? ptr_reg + 3'h1 : (pop_i ? top_idx : ptr_reg);

  // Pointer
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ptr_reg <= 3'h0;
    end else begin
      ptr_reg <= ptr_next;
    end
  end

  // Entry storage
  always_ff @(posedge clk_i) begin
    if (push_i) begin
      mem[ptr_reg] <= push_data_i;
    end
  end

endmodule : cie_ret_stack
`default_nettype wire

// ### cie_rotate.sv
`timescale 1ns/1ps
`default_nettype none
module cie_rotate
  import cie_pkg::*;
(
  // Operand
  input  wire logic       left_i,
  input  wire logic [7:0] value_i,
  input  wire logic       carry_i,
  // Result
  output logic [7:0]      result_o,
  output logic            carry_o
);

  // Rotate through carry in either direction
  assign result_o = left_i ? {value_i[6:0], carry_i} : {carry_i, value_i[7:1]};
  assign carry_o  = left_i ? value_i[7] : value_i[0];

endmodule : cie_rotate

// ### cpu_instr_exec_subset.sv
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module cpu_instr_exec_subset
  import cie_pkg::*;
(
  // Clock and reset
  input  wire logic            CLK_I,
  input  wire logic            NRST_I,
  // Instruction stream
  input  wire logic [13:0]     INSTR_I,
  input  wire logic            INSTR_VALID_I,
  // Call and interrupt pushes
  input  wire logic            STACK_PUSH_I,
  input  wire logic [PC_W-1:0] PUSH_ADDR_I,
  // Wake from sleep
  input  wire logic            WAKE_I,
  // File register access
  output logic [6:0]           FILE_ADDR_O,
  input  wire logic [7:0]      FILE_RDATA_I,
  output var cie_file_wr_t     FILE_WR_O,
  // Register port
  input  wire logic [1:0]      REG_ADDR_I,
  input  wire logic [7:0]      REG_WDATA_I,
  input  wire logic            REG_WE_I,
  input  wire logic            REG_RE_I,
  output logic [7:0]           REG_RDATA_O,
  // Core state
  output logic [7:0]           ACC_O,
  output logic [PC_W-1:0]      PC_O,
  output logic                 CARRY_O,
  output logic                 IRQ_ENABLE_O,
  output logic                 POWERDOWN_O,
  output logic                 TO_O,
  output logic                 FLUSH_O,
  output logic                 SLEEP_O,
  output logic                 OSC_HALT_O,
  output logic                 WDT_CLEAR_O
);

  cie_state_t      state_reg;
  cie_state_t      state_next;
  cie_dec_t        dec;
  cie_file_wr_t    file_wr_reg;
  cie_file_wr_t    file_wr_next;
  logic [7:0]      acc_reg;
  logic [7:0]      acc_next;
  logic [7:0]      irqctl_reg;
  logic [7:0]      irqctl_next;
  logic [PC_W-1:0] pc_reg;
  logic [PC_W-1:0] pc_next;
  logic            carry_reg;
  logic            carry_next;
  logic            powerdown_reg;
  logic            powerdown_next;
  logic            to_reg;
  logic            to_next;
  logic            wdt_clr_reg;
  logic [7:0]      rdata_reg;
  logic [7:0]      rdata_next;
  logic            exec;
  logic            any_ret;
  logic            any_rot;
  logic            rot_to_file;
  logic [7:0]      rot_result;
  logic            rot_carry;
  logic [PC_W-1:0] stack_top;
  logic            sw_irqctl_we;
  logic            sw_acc_we;

  // Execution qualifier: only in run state with a valid word
  assign exec = INSTR_VALID_I && (state_reg == ST_RUN);

  assign dec.lit_load  = exec && (INSTR_I[13:10] == LIT_LOAD_TOP);
  assign dec.ret_lit   = exec && (INSTR_I[13:10] == LIT_RET_TOP);
  // Store decode; no-op falls through with no effect
  assign dec.store     = exec && (INSTR_I[13:7] == STORE_TOP);
  assign dec.ret       = exec && (INSTR_I == OPC_RETURN);
  assign dec.ret_irq   = exec && (INSTR_I == OPC_RET_IRQ);
  assign dec.rot_left  = exec && (INSTR_I[13:8] == ROT_LEFT_TOP);
  assign dec.rot_right = exec && (INSTR_I[13:8] == ROT_RIGHT_TOP);
  assign dec.sleep     = exec && (INSTR_I == OPC_SLEEP);

  // Grouped decode terms
  assign any_ret      = dec.ret || dec.ret_lit || dec.ret_irq;
  assign any_rot      = dec.rot_left || dec.rot_right;
  assign rot_to_file  = any_rot && INSTR_I[DEST_BIT];
  assign sw_irqctl_we = REG_WE_I && (REG_ADDR_I == REG_IRQCTL);
  assign sw_acc_we    = REG_WE_I && (REG_ADDR_I == REG_ACC);
  assign FILE_ADDR_O  = INSTR_I[6:0];

  // Rotate unit
  cie_rotate u_rotate (
    .left_i   (dec.rot_left),
    .value_i  (FILE_RDATA_I),
    .carry_i  (carry_reg),
    .result_o (rot_result),
    .carry_o  (rot_carry)
  );

  // Return stack, popped by every return form
  cie_ret_stack u_stack (
    .clk_i       (CLK_I),
    .nrst_i      (NRST_I),
    .push_i      (STACK_PUSH_I),
    .push_data_i (PUSH_ADDR_I),
    .pop_i       (any_ret),
    .top_o       (stack_top)
  );

  // Sequencing: returns flush one slot, sleep halts until wake
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_RUN: begin
        if (any_ret) begin
          state_next = ST_FLUSH;
        end else if (dec.sleep) begin
          state_next = ST_SLEEP;
        end
      end
      ST_FLUSH: begin
        state_next = ST_RUN;
      end
      ST_SLEEP: begin
        if (WAKE_I) begin
          state_next = ST_RUN;
        end
      end
    endcase
  end

  // Program counter: returns take the popped top, else step on each slot outside sleep
  always_comb begin
    pc_next = pc_reg;
    if (any_ret) begin
      pc_next = stack_top;
    end else if (state_reg != ST_SLEEP) begin
      pc_next = pc_reg + 13'h0001;
    end
  end

  // Accumulator: instruction results win over a software write
  always_comb begin
    acc_next = sw_acc_we ? REG_WDATA_I : acc_reg;
    if (dec.lit_load || dec.ret_lit) begin
      acc_next = INSTR_I[7:0];
    end else if (any_rot && !INSTR_I[DEST_BIT]) begin
      acc_next = rot_result;
    end
  end

  // Flags: only rotates touch carry, only sleep touches pd and to
  always_comb begin
    carry_next  = any_rot ? rot_carry : carry_reg;
    powerdown_next = dec.sleep ? 1'b0 : powerdown_reg;
    to_next     = dec.sleep ? 1'b1 : to_reg;
    irqctl_next = sw_irqctl_we ? REG_WDATA_I : irqctl_reg;
    // Hardware set beats a software clear
    if (dec.ret_irq) begin
      irqctl_next[IRQ_ENABLE_BIT] = 1'b1;
    end
  end

  // File register write-back
  always_comb begin
    file_wr_next      = '0;
    file_wr_next.addr = INSTR_I[6:0];
    if (dec.store) begin
      file_wr_next.we   = 1'b1;
      file_wr_next.data = acc_reg;
    end else if (rot_to_file) begin
      file_wr_next.we   = 1'b1;
      file_wr_next.data = rot_result;
    end
  end

  // Register port read mux
  always_comb begin
    rdata_next = 8'h00;
    if (REG_RE_I) begin
      unique case (REG_ADDR_I)
        REG_ACC:    rdata_next = acc_reg;
        REG_STATUS: begin
          rdata_next[ST_CARRY_BIT]     = carry_reg;
          rdata_next[ST_POWERDOWN_BIT] = powerdown_reg;
          rdata_next[ST_TO_BIT]        = to_reg;
        end
        REG_IRQCTL: rdata_next = irqctl_reg;
        default:    rdata_next = 8'h00;
      endcase
    end
  end

  // State registers
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state_reg   <= ST_RUN;
      pc_reg      <= PC_RST;
      acc_reg     <= ACC_RST;
      carry_reg   <= CARRY_RST;
      powerdown_reg <= POWERDOWN_RST;
      to_reg      <= TO_RST;
      irqctl_reg  <= IRQCTL_RST;
    end else begin
      state_reg   <= state_next;
      pc_reg      <= pc_next;
      acc_reg     <= acc_next;
      carry_reg   <= carry_next;
      powerdown_reg <= powerdown_next;
      to_reg      <= to_next;
      irqctl_reg  <= irqctl_next;
    end
  end

  // Output registers
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      file_wr_reg <= '0;
      rdata_reg   <= 8'h00;
      wdt_clr_reg <= 1'b0;
    end else begin
      file_wr_reg <= file_wr_next;
      rdata_reg   <= rdata_next;
      wdt_clr_reg <= dec.sleep;
    end
  end

  // Output drive
  assign FILE_WR_O   = file_wr_reg;
  assign REG_RDATA_O = rdata_reg;
  assign ACC_O       = acc_reg;
  assign PC_O        = pc_reg;
  assign CARRY_O     = carry_reg;
  assign IRQ_ENABLE_O = irqctl_reg[IRQ_ENABLE_BIT];
  assign POWERDOWN_O  = powerdown_reg;
  assign TO_O        = to_reg;
  assign FLUSH_O     = (state_reg == ST_FLUSH);
  assign SLEEP_O     = (state_reg == ST_SLEEP);
  assign OSC_HALT_O  = (state_reg == ST_SLEEP);
  assign WDT_CLEAR_O = wdt_clr_reg;

  // Checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);

  sequence s_ret_exec;
    INSTR_VALID_I && !FLUSH_O && !SLEEP_O && (INSTR_I == OPC_RETURN || INSTR_I == OPC_RET_IRQ
      || INSTR_I[13:10] == LIT_RET_TOP);
  endsequence

  sequence s_flush_then_run;
    FLUSH_O ##1 !FLUSH_O;
  endsequence

  sequence s_sleep_exec;
    INSTR_VALID_I && !FLUSH_O && !SLEEP_O && INSTR_I == OPC_SLEEP;
  endsequence

  a_lit_load_acc: assert property (dec.lit_load |=> ACC_O == $past(INSTR_I[7:0])
    && $stable(CARRY_O) && $stable(POWERDOWN_O) && $stable(TO_O))
    else $error("literal load result wrong");
  a_ret_irq_enable: assert property (dec.ret_irq |=> IRQ_ENABLE_O && FLUSH_O)
    else $error("return from irq left irq enable clear");
  a_ret_two_cycle: assert property (s_ret_exec |=> s_flush_then_run)
    else $error("return did not take two cycles");
  a_ret_pc_top: assert property (any_ret |=> PC_O == $past(stack_top))
    else $error("return did not load stack top");
  a_rot_left_carry: assert property (dec.rot_left |=> CARRY_O == $past(FILE_RDATA_I[7]))
    else $error("rotate left carry wrong");
  a_rot_right_res: assert property (dec.rot_right && !INSTR_I[DEST_BIT]
    |=> ACC_O == {$past(carry_reg), $past(FILE_RDATA_I[7:1])} && CARRY_O == $past(FILE_RDATA_I[0]))
    else $error("rotate right result wrong");
  a_rot_file_dest: assert property (rot_to_file |=> FILE_WR_O.we
    && FILE_WR_O.addr == $past(INSTR_I[6:0]) && $stable(ACC_O))
    else $error("rotate to file not written");
  a_ret_lit_acc: assert property (dec.ret_lit |=> ACC_O == $past(INSTR_I[7:0])
    && PC_O == $past(stack_top) && $stable(CARRY_O))
    else $error("return with literal wrong");
  a_ret_plain_keep: assert property (dec.ret && !sw_acc_we |=> $stable(ACC_O)
    && $stable(CARRY_O))
    else $error("plain return changed state");
  a_sleep_flags: assert property (s_sleep_exec |=> !POWERDOWN_O && TO_O && WDT_CLEAR_O
    && SLEEP_O && OSC_HALT_O)
    else $error("sleep entry flags wrong");
  a_store_acc: assert property (dec.store |=> FILE_WR_O.we
    && FILE_WR_O.data == $past(acc_reg))
    else $error("store did not copy acc");

endmodule : cpu_instr_exec_subset
`default_nettype wire

// ### cpu_instr_exec_subset_bench.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_instr_exec_subset_bench;
  import cie_pkg::*;

  // Design stimulus and observation
  logic            clk       = 1'b0;
  logic            nrst      = 1'b0;
  logic [13:0]     instr     = 14'h0000;
  logic            valid     = 1'b0;
  logic            push      = 1'b0;
  logic [PC_W-1:0] push_addr = 13'h0000;
  logic            wake      = 1'b0;
  logic [1:0]      reg_addr  = 2'h0;
  logic [7:0]      reg_wdata = 8'h00;
  logic            reg_we    = 1'b0;
  logic            reg_re    = 1'b0;
  logic [7:0]      reg_rdata;
  logic [6:0]      file_addr;
  cie_file_wr_t    file_wr;
  logic [7:0]      acc;
  logic [PC_W-1:0] pc;
  logic            carry, irq_en, pwr_down, to, flush, sleep, halt, wdt_clr;
  logic [7:0]      fmem [0:127];
  wire  [7:0]      file_rdata = fmem[file_addr];

  // Bookkeeping
  int              err_total   = 0;
  int              comparisons = 0;
  int              cyc         = 0;
  logic [15:0]     fq [$];
  logic [15:0]     rq [$];
  logic            re_d        = 1'b0;
  logic [7:0]      acc_e       = 8'h00;
  logic            c_e         = 1'b0;
  logic [PC_W-1:0] stk [0:2];

  // Clock
  always #2.5 clk = ~clk;

  cpu_instr_exec_subset u_dut (
    .CLK_I(clk), .NRST_I(nrst), .INSTR_I(instr), .INSTR_VALID_I(valid),
    .STACK_PUSH_I(push), .PUSH_ADDR_I(push_addr), .WAKE_I(wake),
    .FILE_ADDR_O(file_addr), .FILE_RDATA_I(file_rdata), .FILE_WR_O(file_wr),
    .REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata), .REG_WE_I(reg_we), .REG_RE_I(reg_re),
    .REG_RDATA_O(reg_rdata), .ACC_O(acc), .PC_O(pc), .CARRY_O(carry), .IRQ_ENABLE_O(irq_en),
    .POWERDOWN_O(pwr_down), .TO_O(to), .FLUSH_O(flush), .SLEEP_O(sleep), .OSC_HALT_O(halt),
    .WDT_CLEAR_O(wdt_clr)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0 && fq.size() == 0 && rq.size() == 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  // Read data and file writes are matched against the oldest note
  always @(posedge clk) re_d <= reg_re;
  always @(negedge clk) begin
    if (re_d) begin
      if (rq.size() == 0) check(16'hdead, 16'h0000);
      else check({8'h00, reg_rdata}, rq.pop_front());
    end
    if (file_wr.we !== 1'b0) begin
      if (fq.size() == 0) check(16'hdead, 16'h0000);
      else check(file_wr, fq.pop_front());
    end
  end

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      err_total++;
      tally_and_finish();
    end
  end

  task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_we    <= 1'b1;
    @(posedge clk);
    reg_we    <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_re   <= 1'b1;
    rq.push_back({8'h00, exp});
    @(posedge clk);
    reg_re   <= 1'b0;
  endtask : reg_read

  // One instruction; returns one step after the taking edge
  task automatic exec(input logic [13:0] op);
    @(posedge clk);
    instr <= op;
    valid <= 1'b1;
    @(posedge clk);
    valid <= 1'b0;
    #1;
  endtask : exec

  task automatic stack_push(input logic [PC_W-1:0] a);
    @(posedge clk);
    push      <= 1'b1;
    push_addr <= a;
    @(posedge clk);
    push      <= 1'b0;
  endtask : stack_push

  // Return with a literal load offered in its flush slot
  task automatic do_return(input logic [13:0] op, input logic [PC_W-1:0] exp_pc);
    logic [PC_W-1:0] np;
    np = exp_pc + 13'h0001;
    if (op[13:10] == LIT_RET_TOP) acc_e = op[7:0];
    @(posedge clk);
    instr <= op;
    valid <= 1'b1;
    @(posedge clk);
    instr <= {LIT_LOAD_TOP, 2'b00, ~acc_e};
    #1;
    check(pc, exp_pc);
    check(flush, 1'b1);
    @(posedge clk);
    valid <= 1'b0;
    #1;
    check(pc, np);
    check(flush, 1'b0);
    check({acc, 7'h00, carry}, {acc_e, 7'h00, c_e});
  endtask : do_return

  initial begin
    logic [7:0]  v, res, k;
    logic [6:0]  a;
    logic        left, d;
    void'($urandom(32'h1bfc7c62));
    for (int i = 0; i < 128; i++) fmem[i] = 8'($urandom);
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    // Reset values and register port
    reg_read(REG_ACC, ACC_RST);
    reg_read(REG_STATUS, 8'h06);
    reg_read(REG_IRQCTL, IRQCTL_RST);
    reg_read(2'h3, 8'h00);
    reg_write(REG_STATUS, 8'hf8);
    reg_write(REG_IRQCTL, 8'h5a);
    reg_write(REG_ACC, 8'h3c);
    acc_e = 8'h3c;
    reg_read(REG_STATUS, 8'h06);
    reg_read(REG_IRQCTL, 8'h5a);
    reg_read(REG_ACC, 8'h3c);
    // literal load with every value of the ignored bits
    for (int t = 0; t < 4; t++) begin
      k = 8'($urandom);
      exec({LIT_LOAD_TOP, 2'(t), k});
      acc_e = k;
      check({acc, 5'h00, to, pwr_down, carry}, {acc_e, 5'h00, 3'b110});
    end
    a = 7'($urandom);
    fq.push_back({1'b1, a, acc_e});
    exec({STORE_TOP, a});
    check(acc, acc_e);
    exec(14'h0000);
    check({acc, 7'h00, carry}, {acc_e, 7'h00, c_e});
    for (int i = 0; i < 8; i++) begin
      left = i[0];
      d    = i[1];
      a    = 7'($urandom);
      v    = fmem[a];
      res  = left ? {v[6:0], c_e} : {c_e, v[7:1]};
      if (d) fq.push_back({1'b1, a, res});
      else acc_e = res;
      exec({left ? ROT_LEFT_TOP : ROT_RIGHT_TOP, d, a});
      c_e = left ? v[7] : v[0];
      check({acc, 7'h00, carry}, {acc_e, 7'h00, c_e});
      check({pwr_down, to}, 2'b11);
    end
    reg_read(REG_STATUS, {5'h00, 2'b11, c_e});
    // Returns in stack order, each kind once
    for (int j = 0; j < 3; j++) begin
      stk[j] = 13'($urandom) & 13'h0fff;
      stack_push(stk[j]);
    end
    do_return(OPC_RETURN, stk[2]);
    k = 8'($urandom);
    do_return({LIT_RET_TOP, 2'b11, k}, stk[1]);
    do_return(OPC_RET_IRQ, stk[0]);
    check(irq_en, 1'b1);
    reg_read(REG_IRQCTL, 8'hda);
    // Sleep entry, ignored word, wake
    exec(OPC_SLEEP);
    check({pwr_down, to}, 2'b01);
    check(wdt_clr, 1'b1);
    check({sleep, halt}, 2'b11);
    @(posedge clk);
    instr <= {LIT_LOAD_TOP, 2'b00, ~acc_e};
    valid <= 1'b1;
    #1;
    check(wdt_clr, 1'b0);
    @(posedge clk);
    valid <= 1'b0;
    wake  <= 1'b1;
    @(posedge clk);
    wake  <= 1'b0;
    #1;
    check({sleep, halt}, 2'b00);
    check({acc, pwr_down, to}, {acc_e, 2'b01});
    reg_read(REG_STATUS, {5'h00, 2'b10, c_e});
    repeat (3) @(posedge clk);
    tally_and_finish();
  end

endmodule : cpu_instr_exec_subset_bench
`default_nettype wire
